// ---- cssa_consts.vh ----
// Offsets, field positions and timing counts for the charger status bank
`ifndef CSSA_CONSTS_VH
`define CSSA_CONSTS_VH
`define CSSA_OFS_OPTIONS 8'h29
`define CSSA_OFS_TOTAL 8'h30
`define CSSA_OFS_CV 8'h31
`define CSSA_OFS_ABSORB 8'h32
`define CSSA_OFS_EQUAL 8'h33
`define CSSA_OFS_PHASE 8'h34
`define CSSA_OFS_LOOP 8'h35
`define CSSA_OFS_LIMIT 8'h36
`define CSSA_OFS_STATE_ALERT 8'h37
`define CSSA_BIT_CX_TERM 2
`define CSSA_BIT_TEMP_COMP 1
`define CSSA_BIT_REGION_EN 0
`define CSSA_ST_EQUALIZE 10
`define CSSA_ST_ABSORB 9
`define CSSA_ST_SUSPEND 8
`define CSSA_ST_PRECOND 7
`define CSSA_ST_BULK 6
`define CSSA_ST_THERM 5
`define CSSA_ST_TIMER_TERM 4
`define CSSA_ST_CX_TERM 3
`define CSSA_ST_TIME_FAULT 2
`define CSSA_ST_MISSING 1
`define CSSA_ST_SHORT 0
`define CSSA_BIT_MEAS_VALID 15
`define CSSA_CLK_HZ 125000000
`define CSSA_TICK_HZ 1
`define CSSA_SEC_CYCLES (`CSSA_CLK_HZ / `CSSA_TICK_HZ)
`define CSSA_MEAS_CYCLE_US 6500
`define CSSA_MEAS_CYCLES ((`CSSA_CLK_HZ / 1000000) * `CSSA_MEAS_CYCLE_US)
`define CSSA_WARMUP_US 12000
`define CSSA_WARMUP_CYCLES ((`CSSA_CLK_HZ / 1000000) * `CSSA_WARMUP_US)
`endif

// ---- cssa_bank.v ----
// Charger option, phase timer, state, regulation status and limit alert register bank
`timescale 1ns/100ps
`include "cssa_consts.vh"

// Summary of operation
// R1 - Five 5-bit current codes for regions two to six; active one drives target.
// R2 - Regions one and seven have no current; charging pauses there.
// R3 - Option bit 2 enables low-current termination for lithium; resets 0.
// R4 - Option bit 1 enables temperature-compensated voltage for lead-acid; default one.
// R5 - Option bit 0 enables region-qualified charging for lithium; default one.
// R6 - Read-only 16-bit total charge seconds counter at 0x30, lithium only.
// R7 - Read-only 11-bit constant-voltage seconds counter at 0x31, lithium only.
// R8 - Read-only 11-bit absorb seconds counter at 0x32, not for lithium-ion.
// R9 - Writable 16-bit equalize seconds counter at 0x33, lead-acid only.
// R10 - 11-bit charger state word at 0x34 holds at most one set bit.
// R11 - State bits: 10 equalize down to 0 battery short, as listed.
// R12 - Suspend on low input headroom, host suspend bit, or system fault.
// R13 - Lithium-ion shows precondition while battery below 2.9V per cell.
// R14 - Lithium enters timer termination after exceeding the voltage-phase time limit.
// R15 - Lithium enters charge-time fault when total counter exceeds the limit.
// R16 - 4-bit one-hot regulation loop word at 0x35, undervoltage down to voltage.
// R17 - Limit alerts are evaluated at the end of each 6.5ms measurement cycle.
// R18 - An alert bit sets only while its enable bit is set.
// R19 - Alerts stay set until disabled or cleared by writing zero.
// R20 - Clearing an enabled alert whose condition persists re-raises it at the next measurement cycle end.
// R21 - A new alert pulls the alert line low until the response completes.
// R22 - Alert bit 15 rises once the 12ms warm-up has elapsed, if enabled.
// R23 - Enabled state alert bits set on entry into the matching state.
// R24 - Phase timers count seconds from a one-hertz tick and saturate.
// R25 - Writing one to an alert bit leaves it unchanged.
module cssa_bank #(
  parameter SEC_CYCLES = `CSSA_SEC_CYCLES,
  parameter MEAS_CYCLES = `CSSA_MEAS_CYCLES,
  parameter WARMUP_CYCLES = `CSSA_WARMUP_CYCLES
) (
  input wire clk_in, // 125 MHz clock
  input wire rst_n_in, // Async reset, active low
  input wire reg_wr_in, // Register write strobe
  input wire reg_rd_in, // Register read strobe
  input wire [7:0] reg_addr_in, // Register sub-address
  input wire [15:0] reg_wdata_in, // Write data
  output reg [15:0] reg_rdata_out, // Read data, valid cycle after read
  input wire lead_acid_in, // Chemistry is lead-acid
  input wire li_ion_in, // Chemistry is lithium-ion
  input wire [2:0] temp_region_in, // Thermistor region 1..7
  input wire [24:0] region_current_codes_in, // Five 5-bit codes, region 2 in low bits
  input wire low_headroom_in, // Input within 100mV of battery sense pin
  input wire suspend_req_in, // Host suspend control bit
  input wire sys_fault_in, // System fault present
  input wire below_precond_in, // Battery below 2.9V per cell
  input wire charging_in, // Charge cycle active
  input wire at_charge_voltage_in, // Battery at charge voltage
  input wire absorb_active_in, // Algorithm in absorb phase
  input wire equalize_active_in, // Algorithm in equalize phase
  input wire cx_detect_in, // Low current detected
  input wire bat_missing_in, // Battery missing
  input wire bat_short_in, // Battery shorted
  input wire [3:0] loop_active_in, // Raw loop activity, bit 3 highest priority
  input wire [15:0] cv_time_limit_in, // Constant-voltage time limit, seconds
  input wire [15:0] charge_time_limit_in, // Charge time limit, seconds
  input wire [15:0] limit_cond_in, // Limit excursion conditions
  input wire [15:0] limit_enable_in, // Limit alert enables
  input wire [10:0] state_alert_enable_in, // State alert enables
  input wire alert_resp_done_in, // Alert response completed, one-cycle pulse
  output reg [4:0] current_target_out, // Active charge current code
  output reg charge_pause_out, // Charging paused by temperature
  output reg cx_term_en_out, // Low-current termination effective
  output reg temp_comp_en_out, // Temperature compensation effective
  output reg region_en_out, // Region-qualified charging effective
  output reg [10:0] phase_out, // One-hot charger state
  output reg alert_n_out, // Alert line level, low active
  output reg alert_oe_out // Alert line drive enable, high pulls low
);
  // Host-visible registers
  reg [2:0] opt_q;
  reg [15:0] total_q;
  reg [10:0] cv_q;
  reg [10:0] absorb_q;
  reg [15:0] equal_q;
  reg [3:0] loop_q;
  reg [15:0] limit_q;
  reg [10:0] st_alert_q;
  // State, internal counters and next values
  reg [10:0] phase_q;
  reg [10:0] phase_d;
  reg [26:0] sec_cnt_q;
  reg [20:0] meas_cnt_q;
  reg [21:0] warm_cnt_q;
  reg warm_done_q;
  reg alert_q;
  reg [15:0] limit_d;
  reg [10:0] st_alert_d;
  reg [3:0] loop_d;
  reg [4:0] target_d;
  // One-second and measurement-cycle strobes from free-running counters
  wire tick = (sec_cnt_q == SEC_CYCLES - 1);
  wire meas_end = (meas_cnt_q == MEAS_CYCLES - 1);
  // Lithium covers both lithium-ion and iron-phosphate
  wire lithium = ~lead_acid_in;
  // Bit 15 reports warm-up done in place of a limit condition
  wire [15:0] lim_src = {warm_done_q, limit_cond_in[14:0]};
  // States newly entered this cycle, for the state alerts
  wire [10:0] entered = phase_d & ~phase_q;

  // Saturating increment of a 16-bit timer
  function [15:0] sat16;
    input [15:0] v;
    begin
      sat16 = (v == 16'hFFFF) ? v : v + 16'h0001;
    end
  endfunction

  // Saturating increment of an 11-bit timer
  function [10:0] sat11;
    input [10:0] v;
    begin
      sat11 = (v == 11'h7FF) ? v : v + 11'h001;
    end
  endfunction

  // Write strobe aimed at one sub-address
  function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // Write strobes per writable register
  wire wr_opt = wr_hit(reg_wr_in, reg_addr_in, `CSSA_OFS_OPTIONS);
  wire wr_equal = wr_hit(reg_wr_in, reg_addr_in, `CSSA_OFS_EQUAL);
  wire wr_limit = wr_hit(reg_wr_in, reg_addr_in, `CSSA_OFS_LIMIT);
  wire wr_st = wr_hit(reg_wr_in, reg_addr_in, `CSSA_OFS_STATE_ALERT);

  // Charger state selection, highest priority first
  always @* begin
    phase_d = 11'h000;
    // Terminations and the charge-time fault latch until a higher cause takes over
    // R12 suspend conditions
    if (low_headroom_in || suspend_req_in || sys_fault_in) begin
      phase_d[`CSSA_ST_SUSPEND] = 1'b1;
    end else if (bat_short_in) begin
      phase_d[`CSSA_ST_SHORT] = 1'b1;
    end else if (bat_missing_in) begin
      phase_d[`CSSA_ST_MISSING] = 1'b1;
    // R15 charge time fault
    end else if (lithium && (phase_q[`CSSA_ST_TIME_FAULT] ||
                 (charging_in && total_q > charge_time_limit_in))) begin
      phase_d[`CSSA_ST_TIME_FAULT] = 1'b1;
    // Timer is zero-extended for the 16-bit limit compare
    // R14 voltage-phase timeout
    end else if (lithium && (phase_q[`CSSA_ST_TIMER_TERM] ||
                 ({5'h00, cv_q} > cv_time_limit_in && at_charge_voltage_in))) begin
      phase_d[`CSSA_ST_TIMER_TERM] = 1'b1;
    // R3 low-current termination
    end else if (lithium && opt_q[`CSSA_BIT_CX_TERM] && (phase_q[`CSSA_ST_CX_TERM] ||
                 (cx_detect_in && at_charge_voltage_in))) begin
      phase_d[`CSSA_ST_CX_TERM] = 1'b1;
    // R2 thermal pause in outer regions
    end else if (lithium && opt_q[`CSSA_BIT_REGION_EN] &&
                 (temp_region_in == 3'h1 || temp_region_in == 3'h7)) begin
      phase_d[`CSSA_ST_THERM] = 1'b1;
    end else if (charging_in) begin
      // R13 precondition for lithium-ion
      if (li_ion_in && below_precond_in) begin
        phase_d[`CSSA_ST_PRECOND] = 1'b1;
      end else if (lead_acid_in && equalize_active_in) begin
        phase_d[`CSSA_ST_EQUALIZE] = 1'b1;
      end else if (!li_ion_in && absorb_active_in) begin
        phase_d[`CSSA_ST_ABSORB] = 1'b1;
      end else begin
        phase_d[`CSSA_ST_BULK] = 1'b1;
      end
    end
  end

  // Regulation loop one-hot and region current select
  always @* begin
    loop_d = 4'h0;
    // R16 one-hot priority encode
    if (loop_active_in[3]) begin
      loop_d = 4'h8;
    end else if (loop_active_in[2]) begin
      loop_d = 4'h4;
    end else if (loop_active_in[1]) begin
      loop_d = 4'h2;
    end else if (loop_active_in[0]) begin
      loop_d = 4'h1;
    end
    // R1 active region code
    case (temp_region_in)
      3'h2: target_d = region_current_codes_in[4:0];
      3'h3: target_d = region_current_codes_in[9:5];
      3'h4: target_d = region_current_codes_in[14:10];
      3'h5: target_d = region_current_codes_in[19:15];
      3'h6: target_d = region_current_codes_in[24:20];
      default: target_d = 5'h00;
    endcase
  end

  // Alert next values
  always @* begin
    limit_d = limit_q;
    // R25 writes of one keep the bit
    if (wr_limit) begin
      limit_d = limit_d & reg_wdata_in;
    end
    // R19 disabled bits drop
    limit_d = limit_d & limit_enable_in;
    // R17 R18 R20 R22 evaluate at cycle end, set wins
    if (meas_end) begin
      limit_d = limit_d | (lim_src & limit_enable_in);
    end
    // State alerts follow the same clear-then-set order
    st_alert_d = st_alert_q;
    if (wr_st) begin
      st_alert_d = st_alert_d & reg_wdata_in[10:0];
    end
    // R23 set on state entry
    st_alert_d = (st_alert_d & state_alert_enable_in) | (entered & state_alert_enable_in);
  end

  // Tick, measurement and warm-up counters
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_cnt_q <= 27'h0000000;
      meas_cnt_q <= 21'h000000;
      warm_cnt_q <= 22'h000000;
      warm_done_q <= 1'b0;
    end else begin
      // R24 one-hertz tick
      sec_cnt_q <= tick ? 27'h0000000 : sec_cnt_q + 27'h0000001;
      // Measurement cycle end strobes the limit evaluation
      meas_cnt_q <= meas_end ? 21'h000000 : meas_cnt_q + 21'h000001;
      // Warm-up counter stops once done so it cannot wrap
      if (warm_cnt_q == WARMUP_CYCLES - 1) begin
        warm_done_q <= 1'b1;
      end else begin
        warm_cnt_q <= warm_cnt_q + 22'h000001;
      end
    end
  end

  // Registers, timers and state
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      opt_q <= 3'h3;
      total_q <= 16'h0000;
      cv_q <= 11'h000;
      absorb_q <= 11'h000;
      equal_q <= 16'h0000;
      phase_q <= 11'h000;
      loop_q <= 4'h0;
      limit_q <= 16'h0000;
      st_alert_q <= 11'h000;
      alert_q <= 1'b0;
    end else begin
      // R3 R4 R5 option bits
      if (wr_opt) begin
        opt_q <= reg_wdata_in[2:0];
      end
      // R10 R11 one-hot state
      phase_q <= phase_d;
      loop_q <= loop_d;
      limit_q <= limit_d;
      st_alert_q <= st_alert_d;
      // Total, constant-voltage and absorb timers restart from zero when their phase is left; equalize holds
      // R6 total charge timer
      if (!charging_in || !lithium) begin
        total_q <= 16'h0000;
      end else if (tick) begin
        total_q <= sat16(total_q);
      end
      // R7 constant-voltage timer
      if (!lithium || !at_charge_voltage_in) begin
        cv_q <= 11'h000;
      end else if (tick) begin
        cv_q <= sat11(cv_q);
      end
      // R8 absorb timer
      if (li_ion_in || !phase_q[`CSSA_ST_ABSORB]) begin
        absorb_q <= 11'h000;
      end else if (tick) begin
        absorb_q <= sat11(absorb_q);
      end
      // R9 equalize timer, host writable
      if (wr_equal) begin
        equal_q <= reg_wdata_in;
      end else if (lead_acid_in && phase_q[`CSSA_ST_EQUALIZE] && tick) begin
        equal_q <= sat16(equal_q);
      end
      // A response in the cycle of a fresh alert does not release the line
      // R21 hold alert until response, new alert wins
      if ((|(limit_d & ~limit_q)) || (|(st_alert_d & ~st_alert_q))) begin
        alert_q <= 1'b1;
      end else if (alert_resp_done_in) begin
        alert_q <= 1'b0;
      end
    end
  end

  // Read mux and registered outputs
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
      current_target_out <= 5'h00;
      charge_pause_out <= 1'b0;
      cx_term_en_out <= 1'b0;
      temp_comp_en_out <= 1'b0;
      region_en_out <= 1'b0;
      phase_out <= 11'h000;
      alert_n_out <= 1'b1;
      alert_oe_out <= 1'b0;
    end else begin
      // Read data holds between reads; unmapped addresses read zero
      if (reg_rd_in) begin
        case (reg_addr_in)
          `CSSA_OFS_OPTIONS: reg_rdata_out <= {13'h0000, opt_q};
          `CSSA_OFS_TOTAL: reg_rdata_out <= total_q;
          `CSSA_OFS_CV: reg_rdata_out <= {5'h00, cv_q};
          `CSSA_OFS_ABSORB: reg_rdata_out <= {5'h00, absorb_q};
          `CSSA_OFS_EQUAL: reg_rdata_out <= equal_q;
          `CSSA_OFS_PHASE: reg_rdata_out <= {5'h00, phase_q};
          `CSSA_OFS_LOOP: reg_rdata_out <= {12'h000, loop_q};
          `CSSA_OFS_LIMIT: reg_rdata_out <= limit_q;
          `CSSA_OFS_STATE_ALERT: reg_rdata_out <= {5'h00, st_alert_q};
          default: reg_rdata_out <= 16'h0000;
        endcase
      end
      current_target_out <= target_d;
      // R2 pause in outer regions
      charge_pause_out <= phase_q[`CSSA_ST_THERM];
      // R3 R4 R5 chemistry gating
      cx_term_en_out <= lithium & opt_q[`CSSA_BIT_CX_TERM];
      temp_comp_en_out <= lead_acid_in & opt_q[`CSSA_BIT_TEMP_COMP];
      region_en_out <= lithium & opt_q[`CSSA_BIT_REGION_EN];
      phase_out <= phase_q;
      // Alert line level and drive enable mirror the pending flag
      alert_n_out <= ~alert_q;
      alert_oe_out <= alert_q;
    end
  end
endmodule // cssa_bank

// ---- cssa_monitor.sv ----
// Port-level assertions for the charger state and alert register bank
`timescale 1ns/100ps
module cssa_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic lead_acid_in,
  input wire logic [2:0] temp_region_in,
  input wire logic [24:0] region_current_codes_in,
  input wire logic suspend_req_in,
  input wire logic [15:0] limit_enable_in,
  input wire logic [10:0] state_alert_enable_in,
  input wire logic alert_resp_done_in,
  input wire logic [4:0] current_target_out,
  input wire logic cx_term_en_out,
  input wire logic temp_comp_en_out,
  input wire logic region_en_out,
  input wire logic [10:0] phase_out,
  input wire logic alert_n_out,
  input wire logic alert_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Code of the present region moved to the low five bits
  wire [24:0] code_sh = region_current_codes_in >> (5 * (temp_region_in - 3'h2));
  // Host suspend held long enough to pass the state pipeline
  sequence susp_held;
    suspend_req_in [*4];
  endsequence
  // Response done while nothing can raise a fresh alert
  sequence done_idle;
    alert_resp_done_in && limit_enable_in == 16'h0000 && state_alert_enable_in == 11'h000;
  endsequence
  phase_onehot_a: assert property ($onehot0(phase_out))
    else $error("state word not one-hot");
  region_off_a: assert property ($past(temp_region_in) == 3'h1 ||
    $past(temp_region_in) == 3'h7 |-> current_target_out == 5'h00)
    else $error("target set in paused region");
  region_code_a: assert property ($past(rst_n_in) && !$past(lead_acid_in) && region_en_out &&
    $past(temp_region_in) inside {[3'h2:3'h6]} |-> current_target_out == $past(code_sh[4:0]))
    else $error("target differs from region code");
  chem_gate_a: assert property ($past(rst_n_in) |-> ($past(lead_acid_in) ?
    !cx_term_en_out && !region_en_out : !temp_comp_en_out))
    else $error("option on for wrong chemistry");
  alert_pair_a: assert property (alert_n_out == !alert_oe_out)
    else $error("alert level and enable disagree");
  alert_hold_a: assert property (alert_oe_out && !alert_resp_done_in &&
    !$past(alert_resp_done_in) && !$past(alert_resp_done_in, 2) |=> alert_oe_out)
    else $error("alert released without response");
  alert_release_a: assert property (done_idle |-> ##3 !alert_oe_out)
    else $error("alert kept after response");
  alert_cause_a: assert property ($rose(alert_oe_out) |->
    $past(limit_enable_in, 2) != 16'h0000 || $past(state_alert_enable_in, 2) != 11'h000)
    else $error("alert with all enables clear");
  suspend_first_a: assert property (susp_held |-> phase_out == 11'h100)
    else $error("suspend not shown");
  loop_word_a: assert property (reg_rd_in && reg_addr_in == 8'h35 |=>
    reg_rdata_out[15:4] == 12'h000 && $onehot0(reg_rdata_out[3:0]))
    else $error("loop word not one-hot");
endmodule // cssa_monitor

bind cssa_bank cssa_monitor u_cssa_monitor (.*);

// ---- cssa_host.sv ----
// Host model: register strobes and the alert response
`timescale 1ns/100ps
module cssa_host (
  input wire logic clk_in, // Clock
  input wire logic alert_oe_out, // Device pulls alert low
  input wire logic [15:0] reg_rdata_out, // Read data
  output logic reg_wr_in, // Write strobe
  output logic reg_rd_in, // Read strobe
  output logic [7:0] reg_addr_in, // Sub-address
  output logic [15:0] reg_wdata_in, // Write data
  output logic alert_resp_done_in // Response done pulse
);
  wire alert_line = !alert_oe_out; // Pulled up unless driven
  // Idle bus at time zero
  initial {reg_wr_in, reg_rd_in, alert_resp_done_in, reg_addr_in, reg_wdata_in} = 27'h0;
  // One access held over its taking edge; idle bus shows inverted values
  task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk_in);
    #1;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {wr, !wr, a, d};
    @(posedge clk_in);
    #1;
    {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = {2'b00, ~a, ~d};
    @(posedge clk_in);
    #1;
    q = reg_rdata_out;
  endtask
  task automatic ack();
    @(posedge clk_in);
    #1;
    alert_resp_done_in = !alert_line;
    @(posedge clk_in);
    #1;
    alert_resp_done_in = 1'b0;
  endtask
endmodule // cssa_host

// ---- tb_top.sv ----
// Self-checking bench for the charger state, timer and alert bank
`timescale 1ns/100ps
module tb_top;
  localparam int SEC = 10;
  localparam logic [11:0] ST [8] = '{12'h006, 12'h409, 12'hA07, 12'h101, 12'h080, 12'h048,
    12'h028, 12'h018};
  logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, alert_resp_done_in, lead_acid_in, li_ion_in;
  logic low_headroom_in, suspend_req_in, sys_fault_in, below_precond_in, charging_in;
  logic at_charge_voltage_in, absorb_active_in, equalize_active_in, cx_detect_in;
  logic bat_missing_in, bat_short_in, charge_pause_out, cx_term_en_out, temp_comp_en_out;
  logic region_en_out, alert_n_out, alert_oe_out;
  logic [2:0] temp_region_in;
  logic [3:0] loop_active_in;
  logic [4:0] current_target_out;
  logic [7:0] reg_addr_in;
  logic [10:0] state_alert_enable_in, phase_out, seen;
  logic [15:0] reg_wdata_in, reg_rdata_out, cv_time_limit_in, charge_time_limit_in, q, en;
  logic [15:0] limit_cond_in, limit_enable_in;
  logic [24:0] region_current_codes_in;
  int miscompares, n_compared;
  cssa_bank #(.SEC_CYCLES(SEC), .MEAS_CYCLES(8), .WARMUP_CYCLES(20)) u_cssa_bank (.*);
  cssa_host u_cssa_host (.*);
  // Clock at 125 MHz
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  function automatic logic [4:0] exp_target(int r, logic [24:0] c);
    return (r >= 2 && r <= 6) ? c[5 * (r - 2) +: 5] : 5'h00;
  endfunction
  function automatic logic [3:0] exp_loop(logic [3:0] v);
    for (int i = 3; i >= 0; i--) if (v[i]) return 4'h1 << i;
    return 4'h0;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    u_cssa_host.acc(w, a, d, q);
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp, string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset for eight cycles with quiet inputs
  task automatic do_reset();
    rst_n_in = 1'b0;
    {lead_acid_in, li_ion_in, low_headroom_in, suspend_req_in, sys_fault_in, below_precond_in,
      charging_in, at_charge_voltage_in, absorb_active_in, equalize_active_in, cx_detect_in,
      bat_missing_in, bat_short_in} = 13'h0;
    {limit_cond_in, limit_enable_in, state_alert_enable_in, loop_active_in} = 47'h0;
    {cv_time_limit_in, charge_time_limit_in} = 32'hFFFF_FFFF;
    temp_region_in = 3'h4;
    region_current_codes_in = 25'($urandom);
    repeat (8) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
  endtask
  // Hang guard
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  // Main sequence
  initial begin
    void'($urandom(99832));
    do_reset();
    bus(1'b0, 8'h29, 16'h0);
    chk(q, 16'h0003, "option reset");
    chk({cx_term_en_out, temp_comp_en_out, region_en_out}, 3'h1, "lithium gate");
    lead_acid_in = 1'b1;
    cyc(2);
    chk({cx_term_en_out, temp_comp_en_out, region_en_out}, 3'h2, "lead-acid gate");
    lead_acid_in = 1'b0;
    bus(1'b1, 8'h29, 16'hFFFF);
    bus(1'b0, 8'h29, 16'h0);
    chk(q, 16'h0007, "option write");
    bus(1'b1, 8'h30, 16'h5A5A);
    bus(1'b0, 8'h30, 16'h0);
    chk(q, 16'h0000, "read-only timer");
    bus(1'b0, 8'h40, 16'h0);
    chk(q, 16'h0000, "unmapped");
    // Region current codes, pause at the extremes
    charging_in = 1'b1;
    for (int r = 1; r < 8; r++) begin
      temp_region_in = r[2:0];
      region_current_codes_in = 25'($urandom);
      cyc(2);
      chk(current_target_out, exp_target(r, region_current_codes_in), "target");
      chk(charge_pause_out, r == 1 || r == 7, "pause");
    end
    repeat (4) begin
      loop_active_in = 4'($urandom);
      cyc(2);
      bus(1'b0, 8'h35, 16'h0);
      chk(q, exp_loop(loop_active_in), "loop word");
    end
    // Low current at charge voltage outranks the thermal pause
    {cx_detect_in, at_charge_voltage_in} = 2'b11;
    cyc(3);
    chk(phase_out, 11'h008, "low-current term");
    // Each cause alone, in rising priority, with state alerts enabled
    do_reset();
    charging_in = 1'b1;
    state_alert_enable_in = 11'h7FF;
    seen = 11'h0;
    foreach (ST[i]) begin
      {li_ion_in, absorb_active_in, below_precond_in, bat_missing_in, bat_short_in,
        suspend_req_in, low_headroom_in, sys_fault_in} = ST[i][11:4];
      cyc(4);
      seen |= 11'h1 << ST[i][3:0];
      chk(phase_out, 11'h1 << ST[i][3:0], "state bit");
      bus(1'b0, 8'h34, 16'h0);
      chk(q, 11'h1 << ST[i][3:0], "state read");
    end
    bus(1'b0, 8'h37, 16'h0);
    chk(q, seen, "state alerts");
    do_reset();
    charging_in = 1'b1;
    charge_time_limit_in = 16'h0002;
    cyc(5 * SEC);
    chk(phase_out, 11'h004, "time fault");
    do_reset();
    charging_in = 1'b1;
    cyc(2 * SEC + 5);
    bus(1'b0, 8'h30, 16'h0);
    chk(q, 16'h0002, "charge seconds");
    at_charge_voltage_in = 1'b1;
    cv_time_limit_in = 16'h0002;
    cyc(5 * SEC);
    chk(phase_out, 11'h010, "timer term");
    bus(1'b0, 8'h31, 16'h0);
    chk(q, 16'h0005, "cv seconds");
    do_reset();
    lead_acid_in = 1'b1;
    equalize_active_in = 1'b1;
    charging_in = 1'b1;
    bus(1'b1, 8'h33, 16'hFFFE);
    cyc(3 * SEC);
    bus(1'b0, 8'h33, 16'h0);
    chk(q, 16'hFFFF, "equalize saturate");
    {equalize_active_in, absorb_active_in} = 2'b01;
    cyc(3 * SEC);
    bus(1'b0, 8'h32, 16'h0);
    chk(q, 16'h0003, "absorb seconds");
    // Random limit alerts: set, write one, clear, disable, respond
    repeat (3) begin
      do_reset();
      en = 16'($urandom);
      limit_enable_in = en;
      limit_cond_in = 16'($urandom);
      cyc(30);
      bus(1'b0, 8'h36, 16'h0);
      chk(q, en & (limit_cond_in | 16'h8000), "limit set");
      chk(alert_oe_out, |(en & (limit_cond_in | 16'h8000)), "alert low");
      bus(1'b1, 8'h36, 16'hFFFF);
      bus(1'b0, 8'h36, 16'h0);
      chk(q, en & (limit_cond_in | 16'h8000), "write one");
      limit_cond_in = 16'h0;
      bus(1'b1, 8'h36, 16'h0);
      cyc(10);
      bus(1'b0, 8'h36, 16'h0);
      chk(q, en & 16'h8000, "clear re-raise");
      limit_enable_in = 16'h0;
      cyc(2);
      bus(1'b0, 8'h36, 16'h0);
      chk(q, 16'h0, "disable clears");
      u_cssa_host.ack();
      cyc(3);
      chk(alert_oe_out, 1'b0, "alert released");
    end
    close_out();
  end
endmodule // tb_top
